// ==== hdl/lep_eq_mode.v ====
// Receive equalizer mode decode from the control bits
`timescale 1ns/1ns
module lep_eq_mode
(
    input wire eq_auto_disable_i,
    input wire eq_mid_gain_i,
    input wire eq_max_gain_i,
    output reg [1:0] eq_mode_o
);
`include "lep_map.vh"
    always @*
    begin
        if (!eq_auto_disable_i)
            eq_mode_o = `LEP_MODE_AUTO;
        else if (eq_mid_gain_i)
            eq_mode_o = `LEP_MODE_ONE;
        else if (eq_max_gain_i)
            eq_mode_o = `LEP_MODE_TWO;
        else
            eq_mode_o = `LEP_MODE_OFF;
    end
endmodule

// ==== hdl/lep_map.vh ====
// Register map and field constants for the line equalizer and pulse shape registers
`ifndef LEP_MAP_VH
`define LEP_MAP_VH
// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define LEP_IDX_EQ_CTRL 5'h19
`define LEP_IDX_SLOT1 5'h1c
`define LEP_IDX_SLOT2 5'h1d
`define LEP_IDX_SLOT3 5'h1e
`define LEP_IDX_SLOT4 5'h1f
// ----------------------------------------
// Field positions
// ----------------------------------------
`define LEP_EQ_AUTO_DIS_BIT 7
`define LEP_EQ_MID_BIT 6
`define LEP_EQ_MAX_BIT 5
`define LEP_SIGN_BIT 6
`define LEP_COEFF_MSB 5
// ----------------------------------------
// Reset values
// ----------------------------------------
`define LEP_EQ_RST 3'h0
`define LEP_SLOT_RST 7'h00
// ----------------------------------------
// Equalizer mode codes
// ----------------------------------------
`define LEP_MODE_AUTO 2'h0
`define LEP_MODE_OFF 2'h1
`define LEP_MODE_ONE 2'h2
`define LEP_MODE_TWO 2'h3
`endif

// ==== hdl/lep_regs.v ====
// Equalizer control and custom pulse level register bank on classic Wishbone
// Contract
// - Auto-disable bit 7 one leaves automatic equalization; zero runs it automatically.
// - Auto-disable and mid-gain both one select one-stage, about 6 dB.
// - Auto-disable one, mid zero, max one select two-stage, about 12 dB.
// - Pulse-level bit 6 is sign: one positive, zero negative.
// - First slot coefficient bits 5..0, MSB first, 0.1 V per code, resets zero.
// - Second slot coefficient in bits 5..0, bit 5 MSB.
// - Third slot coefficient in bits 5..0, bit 5 MSB.
// - Fourth slot coefficient at index 1FH, bits 5..0.
`timescale 1ns/1ns
module lep_regs
(
    input wire sys_clk_i,
    input wire srst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [6:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output wire eq_auto_disable_o,
    output wire eq_mid_gain_o,
    output wire eq_max_gain_o,
    output wire [1:0] eq_mode_o,
    output wire [3:0] slot_sign_o,
    output wire [23:0] slot_coeff_o
);
`include "lep_map.vh"
// ----------------------------------------
// Bus decode
// ----------------------------------------
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [4:0] idx = wb_adr_i[6:2];
    wire wr_lane0 = req & wb_we_i & wb_sel_i[0];
    reg [2:0] eq_r;
    reg [6:0] slot_r [0:3];
// ----------------------------------------
// Equalizer control, only bits 7..5 stored
// ----------------------------------------
    always @(posedge sys_clk_i)
    begin
        if (srst_i)
            eq_r <= `LEP_EQ_RST;
        else if (wr_lane0 && idx == `LEP_IDX_EQ_CTRL)
            eq_r <= wb_dat_i[`LEP_EQ_AUTO_DIS_BIT:`LEP_EQ_MAX_BIT];
    end
    assign eq_auto_disable_o = eq_r[2];
    assign eq_mid_gain_o = eq_r[1];
    assign eq_max_gain_o = eq_r[0];
// ----------------------------------------
// Pulse level registers, one per slot
// ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_slot
            // Index sum kept as an integer, then cut to the decode width
            localparam integer SLOT_SUM = `LEP_IDX_SLOT1 + g;
            localparam [4:0] SLOT_IDX = SLOT_SUM[4:0];
            always @(posedge sys_clk_i)
            begin
                if (srst_i)
                    slot_r[g] <= `LEP_SLOT_RST;
                else if (wr_lane0 && idx == SLOT_IDX)
                    slot_r[g] <= wb_dat_i[`LEP_SIGN_BIT:0];
            end
            assign slot_sign_o[g] = slot_r[g][`LEP_SIGN_BIT];
            assign slot_coeff_o[6*g+5:6*g] = slot_r[g][`LEP_COEFF_MSB:0];
        end
    endgenerate
// ----------------------------------------
// Mode decode
// ----------------------------------------
    lep_eq_mode u_mode
    (
        .eq_auto_disable_i(eq_r[2]),
        .eq_mid_gain_i(eq_r[1]),
        .eq_max_gain_i(eq_r[0]),
        .eq_mode_o(eq_mode_o)
    );
// ----------------------------------------
// Read data and ack; unmapped reads give zero
// ----------------------------------------
    reg [31:0] rd_nxt;
    always @*
    begin
        rd_nxt = 32'h0000_0000;
        case (idx)
            `LEP_IDX_EQ_CTRL: rd_nxt = {24'h00_0000, eq_r, 5'h00};
            `LEP_IDX_SLOT1: rd_nxt = {25'h000_0000, slot_r[0]};
            `LEP_IDX_SLOT2: rd_nxt = {25'h000_0000, slot_r[1]};
            `LEP_IDX_SLOT3: rd_nxt = {25'h000_0000, slot_r[2]};
            `LEP_IDX_SLOT4: rd_nxt = {25'h000_0000, slot_r[3]};
            default: rd_nxt = 32'h0000_0000;
        endcase
    end
    always @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_nxt : 32'h0000_0000;
        end
    end
endmodule

// ==== testbench/lep_regs_assertions.sv ====
// Checker of the line equalizer and pulse level register bank
`timescale 1ns/1ns
module lep_regs_chk
(
    input wire sys_clk_i, srst_i, wb_ack_o, eq_auto_disable_o, eq_mid_gain_o, eq_max_gain_o,
    input wire [31:0] wb_dat_o,
    input wire [1:0] eq_mode_o,
    input wire [3:0] slot_sign_o,
    input wire [23:0] slot_coeff_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    property p_auto; (eq_mode_o == 2'h0) == !eq_auto_disable_o; endproperty
    a_auto: assert property (p_auto) else $error("auto mode wrong");
    property p_one; eq_auto_disable_o && eq_mid_gain_o |-> eq_mode_o == 2'h2; endproperty
    a_one: assert property (p_one) else $error("one stage wrong");
    property p_two; eq_auto_disable_o && !eq_mid_gain_o && eq_max_gain_o |-> eq_mode_o == 2'h3;
    endproperty
    a_two: assert property (p_two) else $error("two stage wrong");
    // Writes land on the ack edge only, so levels hold between acks
    property p_sign; !$rose(wb_ack_o) && !$past(srst_i) |-> $stable(slot_sign_o); endproperty
    a_sign: assert property (p_sign) else $error("sign moved");
    property p_coef; !$rose(wb_ack_o) && !$past(srst_i) |-> $stable(slot_coeff_o); endproperty
    a_coef: assert property (p_coef) else $error("coeff moved");
    property p_rst; $fell(srst_i) |-> slot_coeff_o == 24'h0 && slot_sign_o == 4'h0; endproperty
    a_rst: assert property (p_rst) else $error("slot not cleared");
    property p_bits; wb_dat_o[31:8] == 24'h0 && (wb_ack_o || wb_dat_o == 32'h0); endproperty
    a_bits: assert property (p_bits) else $error("stray read bits");
    property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack too long");
    c_off: cover property (eq_mode_o == 2'h1);
    c_one: cover property (eq_mode_o == 2'h2);
    c_two: cover property (eq_mode_o == 2'h3);
endmodule
bind lep_regs lep_regs_chk lep_regs_chk_i (.*);

// ==== testbench/tb_lep_regs.sv ====
// Self-checking bench for the equalizer and pulse level registers
`timescale 1ns/1ns
module tb_lep_regs;
    reg sys_clk_i = 0, srst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    reg [6:0] wb_adr_i = 0;
    reg [31:0] wb_dat_i = 0, r = 17;
    reg [3:0] wb_sel_i = 0;
    wire [31:0] wb_dat_o;
    wire [23:0] slot_coeff_o;
    wire [3:0] slot_sign_o;
    wire [1:0] eq_mode_o;
    wire wb_ack_o, eq_auto_disable_o, eq_mid_gain_o, eq_max_gain_o;
    reg [7:0] m [0:31] = '{default: 8'h00};
    integer i, bad_count = 0, n_tests = 0;
    wire [32:0] o = {eq_auto_disable_o, eq_mid_gain_o, eq_max_gain_o, eq_mode_o, slot_sign_o,
        slot_coeff_o};
    wire [32:0] e = {m[25][7:5], m[25][7] ? (m[25][6] ? 2'h2 : m[25][5] ? 2'h3 : 2'h1) : 2'h0,
        m[31][6], m[30][6], m[29][6], m[28][6], m[31][5:0], m[30][5:0], m[29][5:0], m[28][5:0]};
    lep_regs lep_regs_i (.*);
    initial forever #5 sys_clk_i = ~sys_clk_i;
    function [31:0] xs(input [31:0] v);
        xs = v ^ (v << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    task chk(input string nm, input [32:0] s, input [32:0] x);
        n_tests++;
        bad_count += (s !== x);
        if (s !== x) $display("unexpected %s exp %h seen %h", nm, x, s);
    endtask
    task complete_run(input integer extra);
        bad_count += extra;
        if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Hold everything until the ack edge; one idle cycle between accesses
    task xfer(input w, input [6:0] a, input [31:0] d, input [3:0] s);
        @(posedge sys_clk_i) chk("outputs", o, e);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, w, a, d, s};
        do @(posedge sys_clk_i); while (wb_ack_o !== 1'b1);
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        if (!w) chk("read data", wb_dat_o, m[a[6:2]]);
        else if (s[0])
            m[a[6:2]] = d[7:0] & (a[6:2] == 5'h19 ? 8'he0 : a[6:2] > 5'h1b ? 8'h7f : 8'h00);
    endtask
    // Run is about 1000 cycles; the limit leaves wide room
    initial #40000 complete_run(1);
    initial
    begin
        repeat (12) @(posedge sys_clk_i);
        srst_i <= 0;
        for (i = 0; i < 300; i++)
        begin
            r = xs(r);
            if (i < 8) xfer(0, {5'h18 + i[4:0], r[1:0]}, r, r[7:4]);
            else if (i < 16) xfer(1, {5'h19, r[1:0]}, {r[31:8], i[2:0], r[4:0]}, 4'h1);
            else xfer(r[8], {5'h18 + {2'h0, r[11:9]}, r[1:0]}, r, r[15:12]);
        end
        xfer(0, 7'h64, 0, 0);
        complete_run(0);
    end
endmodule
